// ===== measurement_store_status.sv
// measurement store: digit packing, output formats, commands and poll status
`timescale 1ns/10ps
// Summary of operation
// - digit-count command takes one or two digits, value 1 to 13
// - store events then time digits, each LSD first, two nibbles per byte
// - memory layout is the same whatever output format is chosen
// - packed forward format sends bytes in storage order, earlier digit low
// - packed reversed format sends the same bytes in opposite order
// - character format: time MSD first, comma, events MSD first, CR, LF
// - reset letter or device clear empties memory, address counter to zero
// - initiate letter or group execute trigger starts storage
// - halt stops storage; hold-off decides discard or disarm of counter
// - serial poll returns eight status bits, one means active, bit 8 unused
// - bit one latches power failure until a readout clears it
// - bit two flags dead time overrun, never with minimum dead time
// - bit three set while counter is held because memory is full
// - bits five and four encode empty, below half, half or more, full
// - bit six set when counted measurements are complete
// - bit seven and service request raised on the listed conditions
// - latched bits hold until readout; next readout shows current state
// - power-up settings: continuous, hold-off off, fourteen digits, etc.
// - power-up memory empty, status clear except bits one and seven
// - counted mode raises service request on completion
// - full memory stops storage; freed space takes the next measurement
module measurement_store_status #(
	parameter int DEPTH = mstore_pkg::DEPTH_DEFAULT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic dev_clear,
	input wire logic group_trigger,
	input wire logic poll_read,
	output logic [7:0] status_byte,
	output logic srq,
	input wire logic power_fail,
	input wire logic dead_overrun,
	input wire logic meas_valid,
	input wire mstore_pkg::meas_t meas_data,
	output logic meas_ready,
	output logic counter_arm,
	output logic accumulating,
	output mstore_pkg::settings_t settings,
	input wire logic talk_enable,
	output logic out_valid,
	output logic [7:0] out_byte,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int FW = AW + 2;

	if (DEPTH < mstore_pkg::DEPTH_MIN || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least DEPTH_MIN");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PACK = 2'h1
	} store_state_t;

	typedef enum logic [1:0] {
		OT_IDLE = 2'h0,
		OT_SEND = 2'h1
	} out_state_t;

	mstore_pkg::settings_t cfg;
	logic pc_valid;
	logic [7:0] pc_letter;
	logic [13:0] pc_arg;
	logic act_reset;
	logic act_init;
	logic act_halt;

	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic [4:0] tcnt;
	logic [5:0] two_t;
	logic space_ok;
	logic clear_mem;
	logic start_acc;

	store_state_t sstate;
	mstore_pkg::meas_t cap;
	logic [4:0] nib_idx;
	logic [3:0] low_nib;
	logic [3:0] cur_nib;
	logic [5:0] tm_idx;
	logic store_fin;
	logic take;
	logic held_cause;
	logic [13:0] stored_total;
	logic done_event;

	out_state_t ostate;
	logic [5:0] pos;
	logic [5:0] out_len;
	logic [5:0] char_nib;
	logic [7:0] pick;
	logic [7:0] next_out;
	logic load_out;
	logic out_fin;

	logic power_fail_latched_bit;
	logic dead_time_overrun_bit;
	logic counter_held_bit;
	logic count_done_bit;
	logic service_request_bit;
	logic [1:0] fill_code;
	logic power_fail_d;
	logic full_d;
	logic overrun_cause;
	logic srq_event;

	cmd_parser u_parser (
		.clk(clk),
		.resetn(resetn),
		.in_valid(cmd_valid),
		.in_byte(cmd_byte),
		.cmd_valid(pc_valid),
		.cmd_letter(pc_letter),
		.cmd_arg(pc_arg),
		.act_reset(act_reset),
		.act_init(act_init),
		.act_halt(act_halt)
	);

	// derived quantities of the current digit setting
	assign tcnt = {1'b0, cfg.digit_count};
	assign two_t = {tcnt, 1'b0};
	assign space_ok = FW'(fill) + FW'(tcnt) <= FW'(DEPTH);
	assign clear_mem = act_reset || dev_clear;
	assign start_acc = act_init || group_trigger;
	assign settings = cfg;

	// program settings; an out-of-range mode, digit-count or format argument leaves the setting unchanged, dead time and aux take its low four bits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg.format <= mstore_pkg::character_format;
			cfg.counted <= 1'b0;
			cfg.holdoff <= 1'b0;
			cfg.ext_trigger_en <= 1'b0;
			cfg.ext_trigger_pos <= 1'b0;
			cfg.dead_time <= mstore_pkg::minimum_dead_time;
			cfg.aux <= mstore_pkg::AUX_RESET;
			cfg.digit_count <= mstore_pkg::default_digit_count;
			cfg.meas_count <= mstore_pkg::MEAS_COUNT_RESET;
		end else if (pc_valid) begin
			case (pc_letter)
				mstore_pkg::LTR_G: begin
					case (pc_arg)
						mstore_pkg::continuous_accumulate: cfg.counted <= 1'b0;
						mstore_pkg::counted_accumulate: cfg.counted <= 1'b1;
						mstore_pkg::holdoff_off: cfg.holdoff <= 1'b0;
						mstore_pkg::holdoff_on: cfg.holdoff <= 1'b1;
						mstore_pkg::ext_trigger_off: cfg.ext_trigger_en <= 1'b0;
						mstore_pkg::ext_trigger_on: cfg.ext_trigger_en <= 1'b1;
						mstore_pkg::ext_trigger_negative_slope: cfg.ext_trigger_pos <= 1'b0;
						mstore_pkg::ext_trigger_positive_slope: cfg.ext_trigger_pos <= 1'b1;
						default: cfg.counted <= cfg.counted;
					endcase
				end
				mstore_pkg::LTR_T: begin
					// changing this with data stored scrambles its framing
					if (pc_arg >= mstore_pkg::DIGITS_LO && pc_arg <= mstore_pkg::DIGITS_HI)
						cfg.digit_count <= pc_arg[3:0];
				end
				mstore_pkg::LTR_F: begin
					if (pc_arg <= 14'(mstore_pkg::packed_forward_format))
						cfg.format <= mstore_pkg::out_format_t'(pc_arg[1:0]);
				end
				mstore_pkg::LTR_D: cfg.dead_time <= pc_arg[3:0];
				mstore_pkg::LTR_E: cfg.aux <= pc_arg[3:0];
				mstore_pkg::LTR_N: cfg.meas_count <= pc_arg;
				default: cfg.aux <= cfg.aux; // time and suffix letters are ignored here
			endcase
		end
	end

	// accumulation on/off; counted mode stops itself on the last stored result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			accumulating <= 1'b0;
			stored_total <= 14'h0000;
			done_event <= 1'b0;
		end else begin
			done_event <= 1'b0;
			if (start_acc) begin
				accumulating <= 1'b1;
				stored_total <= 14'h0000;
			end else if (act_halt) begin
				accumulating <= 1'b0;
			end else if (store_fin) begin
				stored_total <= stored_total + 14'h0001;
				if (cfg.counted && stored_total + 14'h0001 >= cfg.meas_count) begin
					accumulating <= 1'b0;
					done_event <= 1'b1;
				end
			end
		end
	end

	// full memory holds the counter rather than losing a reading
	assign held_cause = accumulating && !space_ok;
	assign meas_ready = sstate == ST_IDLE && !held_cause;
	assign take = meas_valid && meas_ready;
	assign counter_arm = !cfg.holdoff || (accumulating && space_ok);

	// nibble k of the stream: events digits first, then time digits
	assign tm_idx = 6'(nib_idx) - 6'(tcnt);
	assign cur_nib = (nib_idx < tcnt) ? cap.events[nib_idx * 4 +: 4] :
		cap.time_digits[tm_idx * 4 +: 4];
	assign store_fin = sstate == ST_PACK && 6'(nib_idx) == two_t - 6'h01;

	// packing sequencer, one nibble per clock, a byte every second nibble
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sstate <= ST_IDLE;
			cap <= '0;
			nib_idx <= 5'h00;
			low_nib <= 4'h0;
		end else if (clear_mem) begin
			sstate <= ST_IDLE;
			nib_idx <= 5'h00;
		end else begin
			case (sstate)
				ST_IDLE: begin
					// readings arriving while halted are dropped
					if (take && accumulating) begin
						cap <= meas_data;
						nib_idx <= 5'h00;
						sstate <= ST_PACK;
					end
				end
				ST_PACK: begin
					if (!nib_idx[0])
						low_nib <= cur_nib;
					nib_idx <= nib_idx + 5'h01;
					if (store_fin)
						sstate <= ST_IDLE;
				end
				default: sstate <= ST_IDLE;
			endcase
		end
	end

	// byte writes; layout never looks at the output format
	always_ff @(posedge clk) begin
		if (sstate == ST_PACK && nib_idx[0] && !clear_mem)
			mem[wr_ptr] <= {cur_nib, low_nib};
	end

	// write pointer wraps, so freed bytes are reused
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			wr_ptr <= '0;
		else if (clear_mem)
			wr_ptr <= '0;
		else if (sstate == ST_PACK && nib_idx[0])
			wr_ptr <= wr_ptr + AW'(1);
	end

	// fill counts only whole measurements, so a partial one is never sent
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fill <= '0;
			rd_ptr <= '0;
		end else if (clear_mem) begin
			fill <= '0;
			rd_ptr <= '0;
		end else begin
			fill <= fill + (store_fin ? (AW + 1)'(tcnt) : '0) - (out_fin ? (AW + 1)'(tcnt) : '0);
			if (out_fin)
				rd_ptr <= rd_ptr + AW'(tcnt);
		end
	end

	// output byte for the current position in the chosen format
	assign out_len = (cfg.format == mstore_pkg::character_format) ? two_t + 6'h03 : 6'(tcnt);
	assign char_nib = (pos < 6'(tcnt)) ? two_t - 6'h01 - pos : two_t - pos;
	always_comb begin
		pick = mem[rd_ptr + AW'(char_nib[5:1])];
		next_out = mem[rd_ptr + AW'(pos)];
		case (cfg.format)
			mstore_pkg::packed_forward_format:
				next_out = mem[rd_ptr + AW'(pos)];
			mstore_pkg::packed_reversed_format:
				next_out = mem[rd_ptr + AW'(6'(tcnt) - 6'h01 - pos)];
			mstore_pkg::character_format: begin
				if (pos == 6'(tcnt))
					next_out = mstore_pkg::CHR_COMMA;
				else if (pos == two_t + 6'h01)
					next_out = mstore_pkg::CHR_CR;
				else if (pos == two_t + 6'h02)
					next_out = mstore_pkg::CHR_LF;
				else
					next_out = mstore_pkg::CHR_ZERO | {4'h0, char_nib[0] ? pick[7:4] : pick[3:0]};
			end
			default: next_out = mem[rd_ptr + AW'(pos)];
		endcase
	end

	assign load_out = ostate == OT_SEND && pos < out_len && (!out_valid || out_ready);
	assign out_fin = ostate == OT_SEND && pos == out_len && (!out_valid || out_ready);

	// output sequencer: one measurement per pass, space freed after its last byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ostate <= OT_IDLE;
			pos <= 6'h00;
			out_valid <= 1'b0;
			out_byte <= 8'h00;
		end else if (clear_mem) begin
			ostate <= OT_IDLE;
			pos <= 6'h00;
			out_valid <= 1'b0;
		end else begin
			if (out_valid && out_ready)
				out_valid <= 1'b0;
			case (ostate)
				OT_IDLE: begin
					if (talk_enable && fill >= (AW + 1)'(tcnt) && fill != '0) begin
						pos <= 6'h00;
						ostate <= OT_SEND;
					end
				end
				OT_SEND: begin
					if (load_out) begin
						out_byte <= next_out;
						out_valid <= 1'b1;
						pos <= pos + 6'h01;
					end else if (out_fin) begin
						ostate <= OT_IDLE;
					end
				end
				default: ostate <= OT_IDLE;
			endcase
		end
	end

	// cause edges and fill code
	assign overrun_cause = dead_overrun && cfg.dead_time != mstore_pkg::minimum_dead_time;
	assign srq_event = (power_fail && !power_fail_d) || overrun_cause || done_event ||
		(!space_ok && !full_d);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_fail_d <= 1'b0;
			full_d <= 1'b0;
			fill_code <= mstore_pkg::FILL_EMPTY;
		end else begin
			power_fail_d <= power_fail;
			full_d <= !space_ok;
			if (fill == '0)
				fill_code <= mstore_pkg::FILL_EMPTY;
			else if (!space_ok)
				fill_code <= mstore_pkg::FILL_FULL;
			else if (fill < (AW + 1)'(DEPTH / 2))
				fill_code <= mstore_pkg::FILL_LOW;
			else
				fill_code <= mstore_pkg::FILL_HIGH;
		end
	end

	// latched bits: a new cause in the readout cycle wins over the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_fail_latched_bit <= mstore_pkg::STATUS_RESET[mstore_pkg::BIT_POWER_FAIL];
			dead_time_overrun_bit <= mstore_pkg::STATUS_RESET[mstore_pkg::BIT_OVERRUN];
			counter_held_bit <= mstore_pkg::STATUS_RESET[mstore_pkg::BIT_HELD];
			count_done_bit <= mstore_pkg::STATUS_RESET[mstore_pkg::BIT_DONE];
			service_request_bit <= mstore_pkg::STATUS_RESET[mstore_pkg::BIT_SRQ];
		end else begin
			power_fail_latched_bit <= power_fail || (power_fail_latched_bit && !poll_read);
			dead_time_overrun_bit <= overrun_cause || (dead_time_overrun_bit && !poll_read);
			counter_held_bit <= held_cause || (counter_held_bit && !poll_read);
			count_done_bit <= done_event || (count_done_bit && !poll_read);
			service_request_bit <= srq_event || (service_request_bit && !poll_read);
		end
	end

	// poll byte, one means active, top bit always zero
	always_comb begin
		status_byte = 8'h00;
		status_byte[mstore_pkg::BIT_POWER_FAIL] = power_fail_latched_bit;
		status_byte[mstore_pkg::BIT_OVERRUN] = dead_time_overrun_bit;
		status_byte[mstore_pkg::BIT_HELD] = counter_held_bit;
		status_byte[mstore_pkg::BIT_FILL_LO] = fill_code[0];
		status_byte[mstore_pkg::BIT_FILL_HI] = fill_code[1];
		status_byte[mstore_pkg::BIT_DONE] = count_done_bit;
		status_byte[mstore_pkg::BIT_SRQ] = service_request_bit;
		status_byte[mstore_pkg::BIT_UNUSED] = 1'b0;
	end
	assign srq = service_request_bit;
endmodule

// ===== mstore_pkg.sv
// shared constants and types of the measurement store block
package mstore_pkg;
	// digit capture width from the counter
	localparam int MAX_DIGITS = 14;
	localparam int NIB_W = MAX_DIGITS * 4;
	localparam int DEPTH_DEFAULT = 2048;
	localparam int DEPTH_MIN = 64;

	// accepted digit-count programming range
	localparam logic [13:0] DIGITS_LO = 14'h0001;
	localparam logic [13:0] DIGITS_HI = 14'h000D;
	localparam logic [13:0] ARG_MAX = 14'h270F;

	// command letters
	localparam logic [7:0] LTR_D = 8'h44;
	localparam logic [7:0] LTR_E = 8'h45;
	localparam logic [7:0] LTR_F = 8'h46;
	localparam logic [7:0] LTR_G = 8'h47;
	localparam logic [7:0] LTR_H = 8'h48;
	localparam logic [7:0] LTR_I = 8'h49;
	localparam logic [7:0] LTR_N = 8'h4E;
	localparam logic [7:0] LTR_R = 8'h52;
	localparam logic [7:0] LTR_T = 8'h54;
	localparam logic [7:0] LTR_FIRST = 8'h41;
	localparam logic [7:0] LTR_LAST = 8'h5A;
	localparam logic [3:0] DIGIT_ROW = 4'h3;

	// characters of the character output format
	localparam logic [7:0] CHR_ZERO = 8'h30;
	localparam logic [7:0] CHR_COMMA = 8'h2C;
	localparam logic [7:0] CHR_CR = 8'h0D;
	localparam logic [7:0] CHR_LF = 8'h0A;

	// mode codes carried by the mode command argument
	localparam logic [13:0] continuous_accumulate = 14'h0000;
	localparam logic [13:0] counted_accumulate = 14'h0001;
	localparam logic [13:0] holdoff_off = 14'h0002;
	localparam logic [13:0] holdoff_on = 14'h0003;
	localparam logic [13:0] ext_trigger_off = 14'h0004;
	localparam logic [13:0] ext_trigger_on = 14'h0005;
	localparam logic [13:0] ext_trigger_negative_slope = 14'h0006;
	localparam logic [13:0] ext_trigger_positive_slope = 14'h0007;

	typedef enum logic [1:0] {
		packed_reversed_format = 2'h0,
		character_format = 2'h1,
		packed_forward_format = 2'h2
	} out_format_t;

	// power-up values of the settings
	localparam logic [3:0] default_digit_count = 4'hE;
	localparam logic [3:0] minimum_dead_time = 4'h0;
	localparam logic [3:0] AUX_RESET = 4'h0;
	localparam logic [13:0] MEAS_COUNT_RESET = 14'h0000;

	// poll status byte bit positions and power-up value
	localparam int BIT_POWER_FAIL = 0;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_HELD = 2;
	localparam int BIT_FILL_LO = 3;
	localparam int BIT_FILL_HI = 4;
	localparam int BIT_DONE = 5;
	localparam int BIT_SRQ = 6;
	localparam int BIT_UNUSED = 7;
	localparam logic [7:0] STATUS_RESET = 8'h41;

	// fill level codes
	localparam logic [1:0] FILL_EMPTY = 2'h0;
	localparam logic [1:0] FILL_LOW = 2'h1;
	localparam logic [1:0] FILL_HIGH = 2'h2;
	localparam logic [1:0] FILL_FULL = 2'h3;

	typedef struct packed {
		out_format_t format;
		logic counted;
		logic holdoff;
		logic ext_trigger_en;
		logic ext_trigger_pos;
		logic [3:0] dead_time;
		logic [3:0] aux;
		logic [3:0] digit_count;
		logic [13:0] meas_count;
	} settings_t;

	// digit k of each count sits at bits [4k+3:4k], k = 0 is least significant
	typedef struct packed {
		logic [NIB_W-1:0] time_digits;
		logic [NIB_W-1:0] events;
	} meas_t;
endpackage

// ===== cmd_parser.sv
// ascii program code parser with numeric argument collection
`timescale 1ns/10ps
module cmd_parser (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	output logic cmd_valid,
	output logic [7:0] cmd_letter,
	output logic [13:0] cmd_arg,
	output logic act_reset,
	output logic act_init,
	output logic act_halt
);
	logic pending;
	logic [7:0] letter;
	logic [13:0] arg;
	logic is_digit;
	logic is_letter;
	logic is_action;
	logic [17:0] grown;

	// digit row 0x30-0x3F also carries the ';' and '?' slope codes
	assign is_digit = in_byte[7:4] == mstore_pkg::DIGIT_ROW;
	assign is_letter = in_byte >= mstore_pkg::LTR_FIRST && in_byte <= mstore_pkg::LTR_LAST;
	assign is_action = in_byte == mstore_pkg::LTR_R || in_byte == mstore_pkg::LTR_I ||
		in_byte == mstore_pkg::LTR_H;
	assign grown = 18'(arg) * 18'h0000A + 18'(in_byte[3:0]);

	// bytes handled strictly in arrival order; any non-digit closes the argument
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending <= 1'b0;
			letter <= 8'h00;
			arg <= 14'h0000;
			cmd_valid <= 1'b0;
			cmd_letter <= 8'h00;
			cmd_arg <= 14'h0000;
		end else begin
			cmd_valid <= 1'b0;
			if (in_valid) begin
				if (is_digit) begin
					if (grown > 18'(mstore_pkg::ARG_MAX))
						arg <= mstore_pkg::ARG_MAX; // saturate long numbers
					else
						arg <= grown[13:0];
				end else begin
					if (pending) begin
						cmd_valid <= 1'b1;
						cmd_letter <= letter;
						cmd_arg <= arg;
					end
					pending <= is_letter && !is_action;
					letter <= in_byte;
					arg <= 14'h0000;
				end
			end
		end
	end

	// argument-free commands act at once on their own pulses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			act_reset <= 1'b0;
			act_init <= 1'b0;
			act_halt <= 1'b0;
		end else begin
			act_reset <= in_valid && in_byte == mstore_pkg::LTR_R;
			act_init <= in_valid && in_byte == mstore_pkg::LTR_I;
			act_halt <= in_valid && in_byte == mstore_pkg::LTR_H;
		end
	end
endmodule

// ===== measurement_store_status_chk.sv
// assertion checker watching the measurement store ports
`timescale 1ns/10ps
module measurement_store_status_chk #(
	parameter int DEPTH = mstore_pkg::DEPTH_DEFAULT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic dev_clear,
	input wire logic group_trigger,
	input wire logic poll_read,
	input wire logic [7:0] status_byte,
	input wire logic srq,
	input wire logic power_fail,
	input wire logic dead_overrun,
	input wire logic meas_valid,
	input wire mstore_pkg::meas_t meas_data,
	input wire logic meas_ready,
	input wire logic counter_arm,
	input wire logic accumulating,
	input wire mstore_pkg::settings_t settings,
	input wire logic talk_enable,
	input wire logic out_valid,
	input wire logic [7:0] out_byte,
	input wire logic out_ready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// the request pin and the polled bit must never disagree
	AST_SRQ_MIRROR: assert property (srq == status_byte[6])
		else $error("srq and status bit seven differ");
	AST_TOP_BIT: assert property (status_byte[7] == 1'b0)
		else $error("unassigned status bit is set");
	// a present power failure is latched on the next edge
	AST_PF_LATCH: assert property (power_fail |=> status_byte[0])
		else $error("power failure not latched");
	AST_PF_SRQ: assert property ($rose(power_fail) |=> srq)
		else $error("power failure raised no service request");
	AST_POLL_CLEAR: assert property (poll_read && !power_fail |=> !status_byte[0])
		else $error("power fail bit survived a readout");
	// minimum dead time can never flag an overrun
	AST_MIN_DEAD: assert property (
		dead_overrun && settings.dead_time == 4'h0 && !status_byte[1] |=> !status_byte[1])
		else $error("overrun flagged at minimum dead time");
	AST_OVERRUN: assert property (
		dead_overrun && settings.dead_time != 4'h0 |=> status_byte[1] && srq)
		else $error("overrun not flagged");
	AST_CLEAR_EMPTY: assert property (dev_clear |-> ##2 status_byte[4:3] == 2'h0)
		else $error("device clear left memory filled");
	AST_HALT: assert property (cmd_valid && cmd_byte == 8'h48 |-> ##[2:4] !accumulating)
		else $error("halt did not stop storage");
	AST_INIT: assert property (
		group_trigger || (cmd_valid && cmd_byte == 8'h49) |-> ##[1:4] accumulating)
		else $error("initiate did not start storage");
	// an offered byte stays put until taken, unless a clear aborts it
	AST_OUT_HOLD: assert property (
		out_valid && !out_ready && !dev_clear |=> out_valid && $stable(out_byte))
		else $error("output byte changed while stalled");
	cover property (out_valid && !out_ready);
	cover property (status_byte[4:3] == 2'h3);
	cover property (poll_read && status_byte[5]);
endmodule

// ===== bus_ctl_model.sv
// bus controller model: sends program codes and takes output bytes
`timescale 1ns/10ps
module bus_ctl_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic out_valid,
	input wire logic [7:0] out_byte,
	output logic out_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_byte
);
	logic [7:0] rx[$];
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
	end
	// one byte per cycle in string order, arguments as ascii digits
	task automatic send(string s);
		for (int i = 0; i < s.len(); i++) begin
			cmd_valid = 1'b1;
			cmd_byte = s[i];
			@(posedge clk);
			#1;
		end
		cmd_valid = 1'b0;
		cmd_byte = ~cmd_byte; // a released bus must not keep the last byte
	endtask
	// a slow taker stalls every other cycle so held bytes are exercised
	always @(posedge clk or negedge resetn) begin
		if (!resetn) out_ready <= 1'b0;
		else out_ready <= #1 slow ? ~out_ready : 1'b1;
	end
	always @(posedge clk) if (out_valid === 1'b1 && out_ready === 1'b1) rx.push_back(out_byte);
endmodule

// ===== measurement_store_status_bench.sv
// self-checking bench for the measurement store block
`timescale 1ns/10ps
module measurement_store_status_bench;
	localparam int DEPTH = 64; // small memory keeps the fill tests short
	localparam logic [55:0] EV = 56'h13572468091357;
	localparam logic [55:0] TM = 56'h98765432109876;
	typedef struct {
		int f;
		int t;
	} row_t;
	// ordinary cases: output format beside digit count
	row_t rows[6] = '{'{2, 1}, '{2, 13}, '{0, 3}, '{0, 12}, '{1, 1}, '{1, 13}};
	logic clk = 0, resetn = 0, dev_clear = 0, group_trigger = 0, poll_read = 0;
	logic power_fail = 0, dead_overrun = 0, meas_valid = 0, talk_enable = 0, slow = 0;
	mstore_pkg::meas_t meas_data = '0;
	logic [7:0] status_byte, out_byte, cmd_byte;
	logic srq, meas_ready, counter_arm, accumulating, out_valid, out_ready, cmd_valid;
	mstore_pkg::settings_t settings;
	logic [7:0] exq[$];
	int err_total = 0, n_compared = 0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	measurement_store_status #(.DEPTH(DEPTH)) dut (.clk(clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .dev_clear(dev_clear),
		.group_trigger(group_trigger), .poll_read(poll_read), .status_byte(status_byte),
		.srq(srq), .power_fail(power_fail), .dead_overrun(dead_overrun),
		.meas_valid(meas_valid), .meas_data(meas_data), .meas_ready(meas_ready),
		.counter_arm(counter_arm), .accumulating(accumulating), .settings(settings),
		.talk_enable(talk_enable), .out_valid(out_valid), .out_byte(out_byte),
		.out_ready(out_ready));
	bus_ctl_model ctl (.clk(clk), .resetn(resetn), .slow(slow), .out_valid(out_valid),
		.out_byte(out_byte), .out_ready(out_ready), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic pulse(ref logic p);
		p = 1'b1;
		tick();
		p = 1'b0;
		tick();
	endtask
	// status is sampled in the readout cycle itself
	task automatic poll(output logic [7:0] s);
		poll_read = 1'b1;
		s = status_byte;
		tick();
		poll_read = 1'b0;
		tick();
	endtask
	// offer one measurement, held until taken or the limit runs out
	task automatic store(int lim, output bit took);
		meas_data = '{time_digits: TM, events: EV};
		meas_valid = 1'b1;
		took = 0;
		repeat (lim) begin
			@(posedge clk);
			if (meas_ready === 1'b1) took = 1;
			#1;
			if (took) break;
		end
		meas_valid = 1'b0;
		meas_data = ~meas_data;
	endtask
	function automatic logic [3:0] nib(int n, int t);
		return n < t ? EV[4*n +: 4] : TM[4*(n-t) +: 4];
	endfunction
	// expected byte stream for one measurement in a given format
	task automatic build(int f, int t);
		logic [7:0] b;
		exq = {};
		if (f == 1) begin
			for (int i = t - 1; i >= 0; i--) exq.push_back(mstore_pkg::CHR_ZERO | {4'h0, TM[4*i +: 4]});
			exq.push_back(mstore_pkg::CHR_COMMA);
			for (int i = t - 1; i >= 0; i--) exq.push_back(mstore_pkg::CHR_ZERO | {4'h0, EV[4*i +: 4]});
			exq.push_back(mstore_pkg::CHR_CR);
			exq.push_back(mstore_pkg::CHR_LF);
		end else begin
			for (int j = 0; j < t; j++) begin
				b = {nib(2*j+1, t), nib(2*j, t)};
				if (f == 2) exq.push_back(b);
				else exq.push_front(b);
			end
		end
	endtask
	// an empty queue pops unknown, so a short stream shows as a mismatch
	task automatic drain();
		for (int k = 0; k < 4000 && ctl.rx.size() < exq.size(); k++) tick();
		while (exq.size()) chk("out_byte", ctl.rx.pop_front(), exq.pop_front());
	endtask
	initial begin
		logic [7:0] s;
		bit took;
		mstore_pkg::settings_t es;
		es = '0;
		es.format = mstore_pkg::character_format;
		es.digit_count = 4'hE;
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		tick(2);
		chk("settings", settings, es);
		chk("arm_reset", counter_arm, 1);
		chk("accumulating", accumulating, 0);
		poll(s);
		chk("poll_first", s, 8'h41);
		poll(s);
		chk("poll_second", s, 8'h00);
		// power failure latches and stays while still present
		power_fail = 1'b1;
		tick(2);
		poll(s);
		chk("pf_poll", s, 8'h41);
		power_fail = 1'b0;
		poll(s);
		chk("pf_present", s[0], 1);
		poll(s);
		chk("pf_gone", s, 8'h00);
		pulse(dead_overrun);
		poll(s);
		chk("ovr_min", s, 8'h00);
		ctl.send("D1\n");
		tick(4);
		pulse(dead_overrun);
		poll(s);
		chk("ovr", s, 8'h42);
		ctl.send("D0\n");
		poll(s);
		foreach (rows[i]) begin
			slow = i[0];
			ctl.send($sformatf("RF%0dT%0dI", rows[i].f, rows[i].t));
			tick(4);
			chk("format", settings.format, rows[i].f);
			chk("digits", settings.digit_count, rows[i].t);
			store(50, took);
			talk_enable = 1'b1;
			build(rows[i].f, rows[i].t);
			drain();
			talk_enable = 1'b0;
			slow = 1'b0;
		end
		ctl.send("T5\nT14\nT0\n");
		tick(4);
		chk("digits_refused", settings.digit_count, 5);
		ctl.send("RHG3\n");
		tick(4);
		store(50, took);
		tick(30);
		chk("fill_halted", status_byte[4:3], 0);
		chk("halted", accumulating, 0);
		chk("arm_held", counter_arm, 0);
		// fill memory until it refuses, then free one slot by reading
		ctl.send("F2T8\nRI");
		tick(4);
		for (int k = 1; k <= 8; k++) begin
			store(50, took);
			tick(20);
			chk("fill", status_byte[4:3], k < 4 ? 1 : k < 8 ? 2 : 3);
		end
		store(40, took);
		chk("refused", took, 0);
		chk("held", status_byte[2], 1);
		chk("arm_full", counter_arm, 0);
		chk("srq_full", srq, 1);
		talk_enable = 1'b1;
		store(400, took);
		chk("refill", took, 1);
		build(2, 8);
		drain();
		talk_enable = 1'b0;
		pulse(dev_clear);
		tick(4);
		chk("fill_clear", status_byte[4:3], 0);
		ctl.rx.delete();
		poll(s);
		ctl.send("HG1N2\n");
		tick(4);
		pulse(group_trigger);
		tick(3);
		store(50, took);
		tick();
		store(50, took);
		tick(30);
		chk("counted_stop", accumulating, 0);
		poll(s);
		chk("counted_status", s, 8'h68);
		tally_and_finish();
	end
	// the tests need well under 10k cycles; this span is far beyond that
	initial begin
		#300000;
		err_total++;
		tally_and_finish();
	end
endmodule
bind measurement_store_status measurement_store_status_chk #(.DEPTH(DEPTH)) chk (.clk(clk),
	.resetn(resetn), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .dev_clear(dev_clear),
	.group_trigger(group_trigger), .poll_read(poll_read), .status_byte(status_byte), .srq(srq),
	.power_fail(power_fail), .dead_overrun(dead_overrun), .meas_valid(meas_valid),
	.meas_data(meas_data), .meas_ready(meas_ready), .counter_arm(counter_arm),
	.accumulating(accumulating), .settings(settings), .talk_enable(talk_enable),
	.out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready));
